// ===== logic/ssdl_top.sv
/*
  Digital part of a single-loop synthesizer: three-wire serial loader,
  reference counter, pulse-swallow divider, phase detector, monitor and
  lock detect. All pins are asynchronous to ref_clk; all but rst are sampled
  through two flip-flops; ref_clk must be well above the pin rates.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssdl_params.svh"

module ssdl_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic phase_sense_select,
  input wire logic oscillator_input,
  input wire logic rf_input,
  output logic pump_out,
  output logic pump_oe,
  output logic phase_up_out,
  output logic phase_down_out,
  output logic phase_down_oe,
  output logic lock_detect_output,
  output logic monitor_out
);

  function automatic logic rise(input logic prev, input logic cur);
    rise = cur & ~prev;
  endfunction

  ssdl_pkg::ssdl_state_type st_r;
  ssdl_pkg::ssdl_state_type st_nxt;

  logic [`SSDL_PIN_W-1:0] pins;
  logic sclk_rise;
  logic osc_rise;
  logic rf_rise;
  logic fsel;
  logic [`SSDL_REF_W-1:0] ref_value;
  logic [`SSDL_SWAL_W-1:0] swal_value;
  logic [`SSDL_MAIN_W-1:0] main_value;
  logic [`SSDL_PRE_W-1:0] pre_last;
  logic fr_ev;
  logic fp_ev;
  logic pre_ev;
  logic ref_flag;
  logic rf_flag;
  logic fast;
  logic slow;

  always_comb begin
    pins = '0;
    pins[`SSDL_PIN_SCLK] = serial_clock;
    pins[`SSDL_PIN_SDATA] = serial_data;
    pins[`SSDL_PIN_LOAD] = load_strobe;
    pins[`SSDL_PIN_FSEL] = phase_sense_select;
    pins[`SSDL_PIN_OSC] = oscillator_input;
    pins[`SSDL_PIN_RF] = rf_input;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    sclk_rise = rise(st_r.prev[`SSDL_PIN_SCLK], st_r.sync2[`SSDL_PIN_SCLK]);
    osc_rise = rise(st_r.prev[`SSDL_PIN_OSC], st_r.sync2[`SSDL_PIN_OSC]);
    rf_rise = rise(st_r.prev[`SSDL_PIN_RF], st_r.sync2[`SSDL_PIN_RF]);
    fsel = st_r.sync2[`SSDL_PIN_FSEL];
    ref_value = st_r.ref_latch[`SSDL_REF_W-1:0];
    swal_value = st_r.div_latch[`SSDL_SWAL_LSB +: `SSDL_SWAL_W];
    main_value = st_r.div_latch[`SSDL_MAIN_LSB +: `SSDL_MAIN_W];

    // serial shift, newest bit at bit 0
    if (sclk_rise) begin
      st_nxt.shift = {st_r.shift[`SSDL_SHIFT_W-2:0],
                      st_r.sync2[`SSDL_PIN_SDATA]};
    end

    // level-sensitive load, routed by the last bit
    // word fields sit above the routing bit
    // only the strobe reaches the latches
    if (st_r.sync2[`SSDL_PIN_LOAD]) begin
      if (st_r.shift[0]) begin
        st_nxt.ref_latch = st_r.shift[`SSDL_REF_LATCH_W:1];
      end else begin
        st_nxt.div_latch = st_r.shift[`SSDL_DIV_LATCH_W:1];
      end
    end

    // Reference counter; latch changes take effect at the next reload
    fr_ev = 1'b0;
    if (osc_rise) begin
      if (st_r.ref_cnt <= 14'h0001) begin
        st_nxt.ref_cnt = ref_value;
        fr_ev = 1'b1;
      end else begin
        st_nxt.ref_cnt = st_r.ref_cnt - 14'h0001;
      end
    end

    // modulus select; one extra count while swallowing
    pre_last = (st_r.ref_latch[`SSDL_SW_BIT] ? `SSDL_P_HIGH_SEL
                                             : `SSDL_P_LOW_SEL)
               - ((st_r.swal_cnt != 7'h00) ? 8'h00 : 8'h01);
    pre_ev = 1'b0;
    if (rf_rise) begin
      if (st_r.pre_cnt >= pre_last) begin
        st_nxt.pre_cnt = 8'h00;
        pre_ev = 1'b1;
      end else begin
        st_nxt.pre_cnt = st_r.pre_cnt + 8'h01;
      end
    end

    // swallow then main count, reload together
    fp_ev = 1'b0;
    if (pre_ev) begin
      if (st_r.main_cnt <= 11'h001) begin
        st_nxt.main_cnt = main_value;
        st_nxt.swal_cnt = swal_value;
        fp_ev = 1'b1;
      end else begin
        st_nxt.main_cnt = st_r.main_cnt - 11'h001;
        if (st_r.swal_cnt != 7'h00) begin
          st_nxt.swal_cnt = st_r.swal_cnt - 7'h01;
        end
      end
    end

    if (fr_ev) begin
      st_nxt.ref_tgl = ~st_r.ref_tgl;
    end
    if (fp_ev) begin
      st_nxt.rf_tgl = ~st_r.rf_tgl;
    end

    // two-flag frequency-phase detector, cleared when both lead
    ref_flag = st_r.lead_ref | fr_ev;
    rf_flag = st_r.lead_rf | fp_ev;
    if (ref_flag && rf_flag) begin
      ref_flag = 1'b0;
      rf_flag = 1'b0;
    end
    st_nxt.lead_ref = ref_flag;
    st_nxt.lead_rf = rf_flag;

    // phase select low swaps the two cases
    fast = fsel ? ref_flag : rf_flag;
    slow = fsel ? rf_flag : ref_flag;
    // pump high on fast, low on slow, else floating
    st_nxt.pump_out = fast;
    st_nxt.pump_oe = fast | slow;
    st_nxt.up_out = slow;
    st_nxt.down_oe = fast;
    // low only while an error pulse is open
    st_nxt.lock = ~(ref_flag | rf_flag);
    st_nxt.monitor = fsel ? st_nxt.ref_tgl : st_nxt.rf_tgl;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.ref_latch <= `SSDL_REF_LATCH_RST;
      st_r.div_latch <= `SSDL_DIV_LATCH_RST;
      st_r.ref_cnt <= `SSDL_REF_CNT_RST;
      st_r.main_cnt <= `SSDL_MAIN_CNT_RST;
      st_r.lock <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pump_out = st_r.pump_out;
  assign pump_oe = st_r.pump_oe;
  assign phase_up_out = st_r.up_out;
  // Open drain: only ever pulls low
  assign phase_down_out = 1'b0;
  assign phase_down_oe = st_r.down_oe;
  assign lock_detect_output = st_r.lock;
  assign monitor_out = st_r.monitor;

endmodule // ssdl_top

`default_nettype wire

// ===== logic/ssdl_params.svh
/*
  Constants of the serial divider loader: word layout, latch reset
  values and counter widths. Included by the package and the top module.
*/
`ifndef SSDL_PARAMS_SVH
`define SSDL_PARAMS_SVH

`define SSDL_SHIFT_W 19
`define SSDL_REF_LATCH_W 15
`define SSDL_DIV_LATCH_W 18
`define SSDL_REF_W 14
`define SSDL_SWAL_W 7
`define SSDL_MAIN_W 11
`define SSDL_PRE_W 8
// Synchronised pin positions
`define SSDL_PIN_SCLK 0
`define SSDL_PIN_SDATA 1
`define SSDL_PIN_LOAD 2
`define SSDL_PIN_FSEL 3
`define SSDL_PIN_OSC 4
`define SSDL_PIN_RF 5
`define SSDL_PIN_W 6
// Field positions inside the latches
`define SSDL_SW_BIT 14
`define SSDL_SWAL_LSB 0
`define SSDL_MAIN_LSB 7
// Prescaler moduli (low modulus of each pair)
`define SSDL_P_LOW_SEL 8'h80
`define SSDL_P_HIGH_SEL 8'h40
// Reset latch contents: R = 16383, modulus 64/65; N = 2047, A = 0
`define SSDL_REF_LATCH_RST 15'h7fff
`define SSDL_DIV_LATCH_RST 18'h3ff80
// First count after reset runs from the largest value
`define SSDL_REF_CNT_RST 14'h3fff
`define SSDL_MAIN_CNT_RST 11'h7ff

`endif

// ===== logic/ssdl_pkg.sv
/*
  Types of the serial divider loader. Assumes ssdl_params.svh is on the
  include path.
*/
`default_nettype none
`include "ssdl_params.svh"

package ssdl_pkg;

  typedef struct packed {
    logic [`SSDL_PIN_W-1:0] sync1;
    logic [`SSDL_PIN_W-1:0] sync2;
    logic [`SSDL_PIN_W-1:0] prev;
    logic [`SSDL_SHIFT_W-1:0] shift;
    logic [`SSDL_REF_LATCH_W-1:0] ref_latch;
    logic [`SSDL_DIV_LATCH_W-1:0] div_latch;
    logic [`SSDL_REF_W-1:0] ref_cnt;
    logic [`SSDL_PRE_W-1:0] pre_cnt;
    logic [`SSDL_SWAL_W-1:0] swal_cnt;
    logic [`SSDL_MAIN_W-1:0] main_cnt;
    logic ref_tgl;
    logic rf_tgl;
    logic lead_ref;
    logic lead_rf;
    logic pump_out;
    logic pump_oe;
    logic up_out;
    logic down_oe;
    logic lock;
    logic monitor;
  } ssdl_state_type;

endpackage

`default_nettype wire

// ===== testbench/ssdl_top_props.sv
/* Output checker for ssdl_top, bound below.
   Assumes pins reach outputs in 3 to 4 ref_clk edges. */
`timescale 1ns/1ns
`default_nettype none
module ssdl_top_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic phase_sense_select,
  input wire logic pump_out,
  input wire logic pump_oe,
  input wire logic phase_up_out,
  input wire logic phase_down_out,
  input wire logic phase_down_oe,
  input wire logic lock_detect_output,
  input wire logic monitor_out
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  reset_hold_a: assert property ($fell(rst) |->
    (lock_detect_output && !pump_oe && !monitor_out)[*3]) else $error("rst");
  down_data_a: assert property (!phase_down_out)
    else $error("down data");
  lock_err_a: assert property (lock_detect_output == !pump_oe)
    else $error("lock");
  pump_up_a: assert property (pump_oe |-> pump_out != phase_up_out)
    else $error("pump up");
  up_idle_a: assert property (!pump_oe |-> !phase_up_out)
    else $error("up idle");
  down_pull_a: assert property (phase_down_oe == (pump_oe && pump_out))
    else $error("down pull");
  sense_flip_a: assert property ($fell(phase_sense_select) && pump_oe
    ##1 (pump_oe && !phase_sense_select)[*6] |-> $past(pump_out, 6) != pump_out)
    else $error("sense");
  monitor_rate_a: assert property (phase_sense_select[*8] ##1
    ($changed(monitor_out) && phase_sense_select) ##1 phase_sense_select[*8]
    |-> monitor_out == $past(monitor_out, 8)) else $error("monitor");
  cover property ($fell(lock_detect_output));
  cover property ($changed(monitor_out));
  cover property (pump_oe && !phase_sense_select && phase_up_out);
endmodule // ssdl_top_props
bind ssdl_top ssdl_top_props ssdl_top_props_inst (.ref_clk, .rst,
  .phase_sense_select, .pump_out, .pump_oe, .phase_up_out, .phase_down_out,
  .phase_down_oe, .lock_detect_output, .monitor_out);
`default_nettype wire

// ===== testbench/ssdl_host.sv
/* Host model of the three-wire serial link.
   Assumes the caller enters send just after a ref_clk edge. */
`timescale 1ns/1ns
`default_nettype none
module ssdl_host (
  input wire logic ref_clk,
  output var logic serial_clock,
  output var logic serial_data,
  output var logic load_strobe
);
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end
  // Half link period is 4 edges, giving 400 ns
  task automatic send(input logic [18:0] w, input bit le);
    for (int i = 18; i >= 0; i--) begin
      serial_clock <= 1'b0;
      serial_data <= w[i];
      repeat (4) @(posedge ref_clk);
      serial_clock <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    serial_clock <= 1'b0;
    repeat (4) @(posedge ref_clk);
    load_strobe <= le;
    repeat (8) @(posedge ref_clk);
    load_strobe <= 1'b0;
    // Hold time over: the old bit must not linger
    serial_data <= ~w[0];
    repeat (4) @(posedge ref_clk);
  endtask
endmodule // ssdl_host
`default_nettype wire

// ===== testbench/ssdl_top_bench.sv
/* Self-checking bench of ssdl_top with the host model.
   Assumes ssdl_host and the bound checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module ssdl_top_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic phase_sense_select = 1'b1;
  logic osc = 1'b0;
  logic rf = 1'b0;
  logic m0 = 1'b0;
  logic sclk, sdata, le, p_out, p_oe, up, dn, dn_oe, lock, mon;
  logic [13:0] r;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int per = 0;
  int k;
  int q[$];
  ssdl_host host_inst (.ref_clk(ref_clk), .serial_clock(sclk),
    .serial_data(sdata), .load_strobe(le));
  ssdl_top ssdl_top_inst (.ref_clk(ref_clk), .rst(rst), .serial_clock(sclk),
    .serial_data(sdata), .load_strobe(le),
    .phase_sense_select(phase_sense_select), .oscillator_input(osc),
    .rf_input(rf), .pump_out(p_out), .pump_oe(p_oe), .phase_up_out(up),
    .phase_down_out(dn), .phase_down_oe(dn_oe), .lock_detect_output(lock),
    .monitor_out(mon));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Reload needs up to one old period before a clean one
  task automatic expect_period(input logic [13:0] rv);
    repeat (80) @(posedge ref_clk);
    q.push_back(2 * rv);
    for (k = 0; k < 200 && q.size() != 0; k++) @(posedge ref_clk);
    // A period that never ends counts as a mismatch
    if (q.size() != 0) begin
      check(q.size(), 32'h0);
      q.delete();
    end
  endtask
  always #50 ref_clk = ~ref_clk;
  // Oscillator rises every second edge; RF too slow to end a count
  always @(posedge ref_clk) begin
    osc <= ~osc;
    rf <= 1'($urandom);
    cyc++;
    if (cyc > 45000) begin
      check(32'h0, 32'h1);
      report_and_stop;
    end
  end
  always @(posedge ref_clk) begin
    per++;
    if (mon !== m0) begin
      if (q.size() != 0) check(per, q.pop_front());
      per = 0;
    end
    m0 = mon;
  end
  initial begin
    k = $urandom(55);
    repeat (12) @(posedge ref_clk);
    check({p_oe, up, dn, dn_oe, lock, mon}, 6'h2);
    rst <= 1'b0;
    host_inst.send({4'h1, 14'h6, 1'b1}, 1'b1);
    for (k = 0; k < 40000 && lock !== 1'b0; k++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    check({p_oe, p_out, up, dn_oe, lock}, 5'h1a);
    expect_period(14'h6);
    host_inst.send({4'h1, 14'h7, 1'b1}, 1'b0);
    expect_period(14'h6);
    for (int i = 0; i < 3; i++) begin
      r = 14'h6 + 14'($urandom_range(7));
      host_inst.send({3'h0, 1'($urandom), r, 1'b1}, 1'b1);
      expect_period(r);
    end
    host_inst.send({11'h5, 7'h4, 1'b0}, 1'b1);
    expect_period(r);
    phase_sense_select <= 1'b0;
    repeat (10) @(posedge ref_clk);
    check({p_oe, p_out, up, dn_oe, lock}, 5'h14);
    // RF divider has not ended its first count: its toggle is still 0
    check(mon, 32'h0);
    repeat (40) @(posedge ref_clk);
    check(mon, 32'h0);
    report_and_stop;
  end
endmodule // ssdl_top_bench
`default_nettype wire
